/* hw/cca_pkg.sv */
package cca_pkg;
    // --------------------------------------------------------------
    // array shape
    // --------------------------------------------------------------
    localparam int CCA_NM = 2;
    localparam int CCA_CW = 16;
    // --------------------------------------------------------------
    // register byte addresses
    // --------------------------------------------------------------
    localparam logic [7:0] CCA_CNT_LO = 8'h00;
    localparam logic [7:0] CCA_CNT_HI = 8'h04;
    localparam logic [7:0] CCA_MODE = 8'h08;
    localparam logic [7:0] CCA_CTRL = 8'h0c;
    localparam logic [7:0] CCA_MOD_BASE = 8'h10;
    localparam logic [7:0] CCA_MOD_STRIDE = 8'h10;
    localparam logic [7:0] CCA_MOD_MODE = 8'h00;
    localparam logic [7:0] CCA_MOD_LO = 8'h04;
    localparam logic [7:0] CCA_MOD_HI = 8'h08;
    // --------------------------------------------------------------
    // counter_mode_reg fields
    // --------------------------------------------------------------
    localparam int CCA_ECF_B = 0;
    localparam int CCA_TB_LSB = 1;
    localparam int CCA_CF_B = 5;
    localparam int CCA_IDLE_B = 7;
    // --------------------------------------------------------------
    // array_control_reg fields (event flags at bit n)
    // --------------------------------------------------------------
    localparam int CCA_PIN_LSB = 4;
    localparam int CCA_AIE_B = 6;
    localparam int CCA_GIE_B = 7;
    // --------------------------------------------------------------
    // module_mode_reg fields
    // --------------------------------------------------------------
    localparam int CCA_IE_B = 0;
    localparam int CCA_MAT_B = 3;
    localparam int CCA_CAPN_B = 4;
    localparam int CCA_CAPP_B = 5;
    localparam int CCA_ECOM_B = 6;
    // --------------------------------------------------------------
    // timebase codes and dividers
    // --------------------------------------------------------------
    localparam logic [2:0] CCA_TB_DIV12 = 3'h0;
    localparam logic [2:0] CCA_TB_DIV4 = 3'h1;
    localparam logic [2:0] CCA_TB_T0 = 3'h2;
    localparam logic [2:0] CCA_TB_ECI = 3'h3;
    localparam logic [2:0] CCA_TB_SYS = 3'h4;
    localparam logic [2:0] CCA_TB_OSC8 = 3'h5;
    localparam logic [3:0] CCA_PRE_LAST = 4'hb;
    localparam logic [1:0] CCA_DIV4_LAST = 2'h3;
    localparam logic [2:0] CCA_OSC_LAST = 3'h7;
    localparam logic [15:0] CCA_CNT_MAX = 16'hffff;
    localparam logic [1:0] CCA_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] CCA_HRESP_OKAY = 2'h0;
endpackage

/* hw/cca_top.sv */
`timescale 1ns/1ps
// How it works
// - sixteen-bit up-counter read as two bytes
// - low read snapshots high byte for next read
// - counter reads never disturb counting
// - timebase select picks one of six sources
// - oscillator over eight synchronised before use
// - wrap to zero sets overflow flag
// - overflow enable gates overflow interrupt request
// - overflow flag cleared only by software
// - global and array enables gate all requests
// - idle halt clear keeps counting in idle
// - capture copies counter into module register
// - rising, falling or both edges select capture
// - capture sets event flag and requests interrupt
// - event flag cleared only by software
// - pin level readable to tell capture edge
// - compare equality sets flag and requests interrupt
// - comparator and match enables select timer mode
// - low write clears, high write sets comparator
module cca_top
    import cca_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic [1:0] hresp_out,
    input wire logic [CCA_NM-1:0] module_pin_in,
    input wire logic external_count_input_in,
    input wire logic ext_osc_in,
    input wire logic timer0_ovf_in,
    input wire logic cpu_idle_in,
    output logic irq_out
);
    // --------------------------------------------------------------
    // address decode helpers
    // --------------------------------------------------------------
    function automatic logic [7:0] mod_addr(input int n,
                                            input logic [7:0] off);
        mod_addr = 8'(int'(CCA_MOD_BASE) + n * int'(CCA_MOD_STRIDE)
                      + int'(off));
    endfunction

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [15:0] cnt;
    logic [7:0] snap;
    logic [2:0] tbsel;
    logic ecf, cf, idle_halt, arr_ie, glb_ie;
    logic [CCA_NM-1:0] ccf, ie, mat, capp, capn, ecom;
    logic [15:0] ccap [CCA_NM];
    logic ap_valid, ap_write;
    logic [7:0] ap_addr;
    logic [3:0] presc;
    logic ecnt_s1, ecnt_s2, ecnt_s3;
    logic osc_s1, osc_s2, osc_s3;
    logic [2:0] osc_div;
    logic [CCA_NM-1:0] pin_s1, pin_s2, pin_s3;

    // --------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // --------------------------------------------------------------
    logic take, rd_take, wr;
    logic [7:0] wdat;
    logic [31:0] next_rdata;
    assign take = hsel_in && hready_in && (htrans_in == CCA_HTRANS_NONSEQ);
    assign rd_take = take && !hwrite_in;
    assign wr = ap_valid && ap_write;
    assign wdat = hwdata_in[7:0];

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else begin
            ap_valid <= take;
            ap_write <= hwrite_in;
            ap_addr <= haddr_in[7:0];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hreadyout_out <= 1'b1;
            hresp_out <= CCA_HRESP_OKAY;
            hrdata_out <= 32'h0000_0000;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= CCA_HRESP_OKAY;
            if (rd_take) begin
                hrdata_out <= next_rdata;
            end
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        logic [7:0] a;
        a = haddr_in[7:0];
        next_rdata = 32'h0000_0000;
        if (hit(a, CCA_CNT_LO)) begin
            next_rdata[7:0] = cnt[7:0];
        end else if (hit(a, CCA_CNT_HI)) begin
            next_rdata[7:0] = snap;
        end else if (hit(a, CCA_MODE)) begin
            next_rdata[CCA_ECF_B] = ecf;
            next_rdata[CCA_TB_LSB +: 3] = tbsel;
            next_rdata[CCA_CF_B] = cf;
            next_rdata[CCA_IDLE_B] = idle_halt;
        end else if (hit(a, CCA_CTRL)) begin
            next_rdata[CCA_NM-1:0] = ccf;
            next_rdata[CCA_PIN_LSB +: CCA_NM] = pin_s2;
            next_rdata[CCA_AIE_B] = arr_ie;
            next_rdata[CCA_GIE_B] = glb_ie;
        end
        for (int n = 0; n < CCA_NM; n++) begin
            if (hit(a, mod_addr(n, CCA_MOD_MODE))) begin
                next_rdata[CCA_IE_B] = ie[n];
                next_rdata[CCA_MAT_B] = mat[n];
                next_rdata[CCA_CAPN_B] = capn[n];
                next_rdata[CCA_CAPP_B] = capp[n];
                next_rdata[CCA_ECOM_B] = ecom[n];
            end
            if (hit(a, mod_addr(n, CCA_MOD_LO))) begin
                next_rdata[7:0] = ccap[n][7:0];
            end
            if (hit(a, mod_addr(n, CCA_MOD_HI))) begin
                next_rdata[7:0] = ccap[n][15:8];
            end
        end
    end

    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ecnt_s1 <= 1'b1;
            ecnt_s2 <= 1'b1;
            ecnt_s3 <= 1'b1;
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            ecnt_s1 <= external_count_input_in;
            ecnt_s2 <= ecnt_s1;
            ecnt_s3 <= ecnt_s2;
            osc_s1 <= ext_osc_in;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // pins need one stable clock to survive the sampling chain
    generate
        for (genvar g = 0; g < CCA_NM; g++) begin : g_pin
            always_ff @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    pin_s1[g] <= 1'b0;
                    pin_s2[g] <= 1'b0;
                    pin_s3[g] <= 1'b0;
                end else begin
                    pin_s1[g] <= module_pin_in[g];
                    pin_s2[g] <= pin_s1[g];
                    pin_s3[g] <= pin_s2[g];
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // timebase
    // --------------------------------------------------------------
    logic osc_rise, ecnt_fall, tick, run, adv, ovf;
    assign osc_rise = osc_s2 && !osc_s3;
    assign ecnt_fall = ecnt_s3 && !ecnt_s2;

    // one prescaler serves both /12 and /4 since 4 divides 12
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc <= 4'h0;
        end else if (presc == CCA_PRE_LAST) begin
            presc <= 4'h0;
        end else begin
            presc <= presc + 4'h1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_div <= 3'h0;
        end else if (osc_rise) begin
            osc_div <= osc_div + 3'h1;
        end
    end

    always_comb begin
        case (tbsel)
            CCA_TB_DIV12: tick = (presc == CCA_PRE_LAST);
            CCA_TB_DIV4: tick = (presc[1:0] == CCA_DIV4_LAST);
            CCA_TB_T0: tick = timer0_ovf_in;
            CCA_TB_ECI: tick = ecnt_fall;
            CCA_TB_SYS: tick = 1'b1;
            CCA_TB_OSC8: tick = osc_rise && (osc_div == CCA_OSC_LAST);
            default: tick = 1'b0;
        endcase
    end

    assign run = !(idle_halt && cpu_idle_in);
    assign adv = tick && run;
    assign ovf = adv && (cnt == CCA_CNT_MAX);

    // --------------------------------------------------------------
    // counter and snapshot
    // --------------------------------------------------------------
    logic cnt_lo_wr, cnt_hi_wr;
    assign cnt_lo_wr = wr && hit(ap_addr, CCA_CNT_LO);
    assign cnt_hi_wr = wr && hit(ap_addr, CCA_CNT_HI);

    // software writes override a count in the same cycle
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= 16'h0000;
        end else if (cnt_lo_wr || cnt_hi_wr) begin
            if (cnt_lo_wr) begin
                cnt[7:0] <= wdat;
            end
            if (cnt_hi_wr) begin
                cnt[15:8] <= wdat;
            end
        end else if (adv) begin
            cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            snap <= 8'h00;
        end else if (rd_take && hit(haddr_in[7:0], CCA_CNT_LO)) begin
            snap <= cnt[15:8];
        end
    end

    // --------------------------------------------------------------
    // global mode and control bits
    // --------------------------------------------------------------
    logic mode_wr, ctrl_wr;
    assign mode_wr = wr && hit(ap_addr, CCA_MODE);
    assign ctrl_wr = wr && hit(ap_addr, CCA_CTRL);

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ecf <= 1'b0;
            tbsel <= CCA_TB_DIV12;
            idle_halt <= 1'b0;
            arr_ie <= 1'b0;
            glb_ie <= 1'b0;
        end else begin
            if (mode_wr) begin
                ecf <= wdat[CCA_ECF_B];
                tbsel <= wdat[CCA_TB_LSB +: 3];
                idle_halt <= wdat[CCA_IDLE_B];
            end
            if (ctrl_wr) begin
                arr_ie <= wdat[CCA_AIE_B];
                glb_ie <= wdat[CCA_GIE_B];
            end
        end
    end

    // writing 0 clears, writing 1 leaves; a wrap in the same cycle wins
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cf <= 1'b0;
        end else if (ovf) begin
            cf <= 1'b1;
        end else if (mode_wr && !wdat[CCA_CF_B]) begin
            cf <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // capture / compare modules
    // --------------------------------------------------------------
    logic [CCA_NM-1:0] cap_ev, match_ev, mm_wr, lo_wr, hi_wr;
    logic [15:0] next_cnt;
    assign next_cnt = cnt + 16'h0001;

    always_comb begin
        for (int n = 0; n < CCA_NM; n++) begin
            cap_ev[n] = (capp[n] && pin_s2[n] && !pin_s3[n])
                     || (capn[n] && !pin_s2[n] && pin_s3[n]);
            match_ev[n] = ecom[n] && mat[n] && adv
                       && (next_cnt == ccap[n]);
            mm_wr[n] = wr && hit(ap_addr, mod_addr(n, CCA_MOD_MODE));
            lo_wr[n] = wr && hit(ap_addr, mod_addr(n, CCA_MOD_LO));
            hi_wr[n] = wr && hit(ap_addr, mod_addr(n, CCA_MOD_HI));
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ie <= '0;
            mat <= '0;
            capp <= '0;
            capn <= '0;
            ecom <= '0;
        end else begin
            for (int n = 0; n < CCA_NM; n++) begin
                if (mm_wr[n]) begin
                    ie[n] <= wdat[CCA_IE_B];
                    mat[n] <= wdat[CCA_MAT_B];
                    capn[n] <= wdat[CCA_CAPN_B];
                    capp[n] <= wdat[CCA_CAPP_B];
                    ecom[n] <= wdat[CCA_ECOM_B];
                end
                if (lo_wr[n]) begin
                    ecom[n] <= 1'b0;
                end
                if (hi_wr[n]) begin
                    ecom[n] <= 1'b1;
                end
            end
        end
    end

    // a capture beats a software byte write landing in the same cycle
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int n = 0; n < CCA_NM; n++) begin
                ccap[n] <= 16'h0000;
            end
        end else begin
            for (int n = 0; n < CCA_NM; n++) begin
                if (cap_ev[n]) begin
                    ccap[n] <= cnt;
                end else begin
                    if (lo_wr[n]) begin
                        ccap[n][7:0] <= wdat;
                    end
                    if (hi_wr[n]) begin
                        ccap[n][15:8] <= wdat;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ccf <= '0;
        end else begin
            for (int n = 0; n < CCA_NM; n++) begin
                if (cap_ev[n] || match_ev[n]) begin
                    ccf[n] <= 1'b1;
                end else if (ctrl_wr && !wdat[n]) begin
                    ccf[n] <= 1'b0;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // interrupt request
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= glb_ie && arr_ie
                    && ((cf && ecf) || |(ccf & ie));
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    AST_OVF_SETS_CF: assert property (ovf |=> cf)
        else $error("wrap did not set overflow flag");
    AST_CF_STICKY: assert property
        (cf && !(mode_wr && !wdat[CCA_CF_B]) |=> cf)
        else $error("overflow flag dropped without a clear");
    AST_IRQ_GATED: assert property (!(glb_ie && arr_ie) |=> !irq_out)
        else $error("interrupt without both enables");
    AST_IRQ_CF: assert property
        (glb_ie && arr_ie && cf && ecf |=> irq_out)
        else $error("overflow interrupt missing");
    AST_CNT_INC: assert property
        (adv && !cnt_lo_wr && !cnt_hi_wr |=> cnt == $past(cnt) + 16'h0001)
        else $error("counter did not advance");
    AST_SNAP: assert property
        (rd_take && hit(haddr_in[7:0], CCA_CNT_LO)
         |=> snap == $past(cnt[15:8]))
        else $error("snapshot not taken on low read");
    AST_HALT: assert property
        (idle_halt && cpu_idle_in && !cnt_lo_wr && !cnt_hi_wr
         |=> $stable(cnt))
        else $error("counter moved while halted in idle");
    AST_SYS_RUN: assert property
        (tbsel == CCA_TB_SYS && run && !cnt_lo_wr && !cnt_hi_wr
         ##1 tbsel == CCA_TB_SYS && run && !cnt_lo_wr && !cnt_hi_wr
         |=> cnt == $past(cnt, 2) + 16'h0002)
        else $error("system clock timebase not counting");
    AST_CAP0: assert property
        (cap_ev[0] |=> ccap[0] == $past(cnt) && ccf[0])
        else $error("capture did not load register and flag");
    AST_LO_CLR_ECOM: assert property
        (lo_wr[0] && !hi_wr[0] |=> !ecom[0])
        else $error("low byte write left comparator enabled");
    AST_MATCH0: assert property (match_ev[0] |=> ccf[0])
        else $error("compare match did not set flag");

    COV_OVF: cover property (ovf ##1 irq_out);
    COV_CAP: cover property (cap_ev[0] ##[1:4] irq_out);
    COV_MATCH: cover property (match_ev[1]);
    COV_BOTH_EDGES: cover property (capp[0] && capn[0] && cap_ev[0]);
endmodule

/* verification/cca_edge_src.sv */
`timescale 1ns/1ps
module cca_edge_src (
    input wire logic clk_in,
    output logic [1:0] pin_out,
    output logic eci_out,
    output logic osc_out,
    output logic t0_out
);
    // ------------------------------------------------------------
    // edge sources, each left still between calls
    // ------------------------------------------------------------
    initial begin
        pin_out = 2'h0;
        eci_out = 1'b1;
        osc_out = 1'b0;
        t0_out = 1'b0;
    end

    // four clocks per level, four times the minimum the pins need
    task automatic set_pin(input int m, input logic v);
        @(posedge clk_in);
        pin_out[m] <= v;
        repeat (4) @(posedge clk_in);
    endtask

    task automatic t0_pulse(input int k);
        repeat (k) begin
            @(posedge clk_in);
            t0_out <= 1'b1;
            @(posedge clk_in);
            t0_out <= 1'b0;
        end
    endtask

    // each level held four clocks, so edges stay under clock/4
    task automatic eci_fall(input int k);
        repeat (k) begin
            repeat (4) @(posedge clk_in);
            eci_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            eci_out <= 1'b1;
        end
    endtask

    // oscillator at half the system clock, never above it
    task automatic osc_run(input int k);
        repeat (k) begin
            @(posedge clk_in);
            osc_out <= 1'b1;
            @(posedge clk_in);
            osc_out <= 1'b0;
        end
    endtask
endmodule

/* verification/counter_array_capture_compare_tb_top.sv */
`timescale 1ns/1ps
module counter_array_capture_compare_tb_top import cca_pkg::*;;
    logic core_clk, rst, hwrite, hready, irq, idle, external_count_input, osc, t0;
    logic [1:0] htrans, hresp, pins;
    logic [31:0] haddr, hwdata, hrdata;
    logic hsel;
    logic [2:0] hsize;
    int mismatches = 0;
    int total_checks = 0;
    localparam logic [7:0] ON = 8'hc0;
    localparam logic [7:0] CAPP = 8'h1 << CCA_CAPP_B;
    localparam logic [7:0] CAPN = 8'h1 << CCA_CAPN_B;
    localparam logic [7:0] IE = 8'h1 << CCA_IE_B;
    localparam logic [7:0] ECOM = 8'h1 << CCA_ECOM_B;
    localparam logic [7:0] MAT = 8'h1 << CCA_MAT_B;
    localparam logic [7:0] CF = 8'h1 << CCA_CF_B;

    cca_top uut (.core_clk_in(core_clk), .rst_in(rst), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .module_pin_in(pins), .external_count_input_in(external_count_input),
        .ext_osc_in(osc), .timer0_ovf_in(t0), .cpu_idle_in(idle),
        .irq_out(irq));
    cca_edge_src ep (.clk_in(core_clk), .pin_out(pins), .eci_out(external_count_input),
        .osc_out(osc), .t0_out(t0));

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic chk_irq(input logic e);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // a wait that runs out ends the run as a failure
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            mismatches++;
            stop_test();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        haddr <= {24'h0, a};
        hsize <= 3'h2;
        htrans <= CCA_HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(hrdata, {24'h0, e});
    endtask

    task automatic set_cnt(input logic [15:0] v);
        wr(CCA_CNT_LO, v[7:0]);
        wr(CCA_CNT_HI, v[15:8]);
    endtask

    task automatic rd_cnt(input logic [15:0] v);
        rd(CCA_CNT_LO, v[7:0]);
        rd(CCA_CNT_HI, v[15:8]);
    endtask

    function automatic logic [7:0] ma(input int m, input logic [7:0] o);
        return CCA_MOD_BASE + 8'(m) * CCA_MOD_STRIDE + o;
    endfunction

    function automatic logic [7:0] mb(input logic h, input logic [2:0] tb,
                                      input logic e);
        return (8'(h) << CCA_IDLE_B) | (8'(tb) << CCA_TB_LSB) | 8'(e);
    endfunction

    // counting only happens between the two edges around idle low
    task automatic run(input int n);
        idle <= 1'b0;
        repeat (n) @(posedge core_clk);
        idle <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int m;
        logic [7:0] md;
        logic [15:0] v;
        logic hit;
        logic [15:0] exp [6] = '{16'd4, 16'd12, 16'd3, 16'd3, 16'd48, 16'd2};
        rst = 1'b1;
        haddr = 32'h0;
        hsel = 1'b1;
        hsize = 3'h2;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        idle = 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(CCA_MODE, 8'h00);
        rd(CCA_CTRL, 8'h00);
        rd(8'hfc, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 6; c++) begin
            wr(CCA_MODE, mb(1'b1, 3'(c), 1'b0));
            set_cnt(16'h0);
            idle <= 1'b0;
            case (c)
                2: ep.t0_pulse(3);
                3: ep.eci_fall(3);
                5: ep.osc_run(16);
                default: repeat (48) @(posedge core_clk);
            endcase
            if (c == 2 || c == 3 || c == 5) repeat (8) @(posedge core_clk);
            idle <= 1'b1;
            rd_cnt(exp[c]);
        end
        $display("test timebase done");
        wr(CCA_MODE, mb(1'b1, CCA_TB_SYS, 1'b0));
        set_cnt(16'h34ff);
        rd(CCA_CNT_LO, 8'hff);
        run(2);
        rd(CCA_CNT_HI, 8'h34);
        rd_cnt(16'h3501);
        wr(CCA_MODE, mb(1'b0, CCA_TB_T0, 1'b0));
        set_cnt(16'h0);
        ep.t0_pulse(3);
        rd_cnt(16'h3);
        $display("test snapshot and idle done");
        wr(CCA_MODE, mb(1'b1, CCA_TB_SYS, 1'b1));
        wr(CCA_CTRL, ON);
        set_cnt(16'hffff);
        run(2);
        rd_cnt(16'h1);
        rd(CCA_MODE, mb(1'b1, CCA_TB_SYS, 1'b1) | CF);
        chk_irq(1'b1);
        wr(CCA_CTRL, 8'h40);
        repeat (2) @(posedge core_clk);
        chk_irq(1'b0);
        wr(CCA_CTRL, ON);
        wr(CCA_MODE, mb(1'b1, CCA_TB_SYS, 1'b0) | CF);
        repeat (2) @(posedge core_clk);
        chk_irq(1'b0);
        rd(CCA_MODE, mb(1'b1, CCA_TB_SYS, 1'b0) | CF);
        wr(CCA_MODE, mb(1'b1, CCA_TB_SYS, 1'b0));
        rd(CCA_MODE, mb(1'b1, CCA_TB_SYS, 1'b0));
        $display("test overflow done");
        for (int k = 0; k < 3; k++) begin
            m = (k == 1) ? 1 : 0;
            md = (k == 0) ? CAPP : (k == 1) ? CAPN : (CAPP | CAPN);
            wr(ma(m, CCA_MOD_MODE), md | IE);
            for (int e = 1; e >= 0; e--) begin
                v = 16'ha500 + 16'(k * 2 + e);
                set_cnt(v);
                ep.set_pin(m, e[0]);
                hit = (e == 1) ? md[CCA_CAPP_B] : md[CCA_CAPN_B];
                rd(CCA_CTRL, ON | (8'(hit) << m)
                    | (8'(e) << (CCA_PIN_LSB + m)));
                chk_irq(hit);
                if (hit) begin
                    rd(ma(m, CCA_MOD_LO), v[7:0]);
                    rd(ma(m, CCA_MOD_HI), v[15:8]);
                end
                wr(CCA_CTRL, ON);
            end
        end
        $display("test capture done");
        wr(ma(0, CCA_MOD_MODE), ECOM | MAT | IE);
        wr(ma(0, CCA_MOD_LO), 8'h05);
        rd(ma(0, CCA_MOD_MODE), MAT | IE);
        wr(ma(0, CCA_MOD_HI), 8'h00);
        rd(ma(0, CCA_MOD_MODE), ECOM | MAT | IE);
        set_cnt(16'h0);
        chk_irq(1'b0);
        run(8);
        rd(CCA_CTRL, ON | 8'h01);
        chk_irq(1'b1);
        chk({30'h0, hresp}, {30'h0, CCA_HRESP_OKAY});
        $display("test compare done");
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
endmodule
